// [common/ext_io_regs.vh]
// constants for the external control i/o block: timing, range codes, register map
// assumes a 100 MHz clock and the plain strobe register port
`ifndef EXT_IO_REGS_VH
`define EXT_IO_REGS_VH

// clock period in ns
`define CLK_PERIOD_NS 10
// trigger input least low time, us
`define TRIG_IN_MIN_US 10
// least low time in cycles, rounded up
`define TRIG_IN_MIN_CYC ((`TRIG_IN_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// trigger output least high time, us
`define TRIGGER_OUTPUT_ENABLE_MIN_US 2
`define TRIGGER_OUTPUT_ENABLE_MIN_CYC ((`TRIGGER_OUTPUT_ENABLE_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// counter widths
`define TRIG_IN_CNT_W 11
`define TRIGGER_OUTPUT_ENABLE_CNT_W 8

// current range codes
`define RANGE_H 2'h0
`define RANGE_M 2'h1
`define RANGE_L 2'h2

// control setting codes
`define CTRL_OFF 2'h0
`define CTRL_V 2'h1
`define CTRL_R 2'h2
`define CTRL_RIV 2'h3

// register map, byte addresses
`define ADDR_W 4
`define REG_CTRL 4'h0
`define REG_EVENT 4'h4
`define REG_STATUS 4'h8

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_MRANGE_LSB 2
`define CTRL_MRANGE_MSB 3
`define CTRL_LOAD_ON 4
`define CTRL_SHORT 5
`define CTRL_TRIGGER_OUTPUT_ENABLE_EN 6
`define CTRL_SEQ_PAUSED 7
`define CTRL_RESET 32'h00000000

// event register fields (write one to fire)
`define EV_DYN_SWITCH 0
`define EV_SEQ_STEP 1
`define EV_MSG_CLEAR 2

// status register fields
`define ST_RANGE_LSB 0
`define ST_RANGE_MSB 1
`define ST_ALARM 2
`define ST_ALARM_MSG 3
`define ST_PAUSED 4
`define ST_RESUMED 5
`define ST_EXT_ACTIVE 6

`endif

// [rtl/external_control_io.v]
// external control i/o logic of the rear control connector
// assumes active-low inputs already level shifted, open input reads high
// (trigger input idles high here too); registers over a plain strobe port
// one 100 MHz clock; the long trigger timings come from local counters
//
// Overview of operation
// - external range only while manual range high
// - external inputs act only in V/R/RIV setting
// - decode range pins: HH high, HL middle, LH low
// - range status: off/off high, second middle, first low
// - load-on status follows load state
// - valid trigger resumes a paused sequence
// - alarm active low, held while low
// - alarm raises external-alarm message
// - alarm from instrument or slave alike
// - short contact closes only while shorting
// - trigger pulse on dynamic switch, enabled steps
// - trigger pulse high at least 2us
`timescale 1ns/1ps
`include "ext_io_regs.vh"
module external_control_io (
   input wire clk, // 100 MHz clock
   input wire rst, // asynchronous reset, active high
   input wire [`ADDR_W-1:0] addr, // register byte address
   input wire [31:0] wdata, // write data
   input wire wr, // write strobe
   input wire rd, // read strobe
   output reg [31:0] rdata, // read data, cycle after rd
   input wire range_sel1_n, // range select upper input (pin 9), active low
   input wire range_sel0_n, // range select lower input (pin 8), active low
   input wire trig_in_n, // trigger input, active low pulse
   input wire alarm_in_n, // alarm input, active low
   output reg load_on_status, // high while load on
   output reg range_status1, // first range status output, on for low range
   output reg range_status0, // second range status output, on for middle range
   output reg short_contact, // high = relay contact closed
   output reg trigger_output_enable, // trigger output pulse, active high
   output reg alarm_active, // external alarm held active
   output reg external_alarm_message, // sticky alarm message indication
   output reg seq_resume // one-cycle pulse: paused sequence resumes
);
   // timing counts as integers, then cut to the counter widths on purpose
   localparam integer TIN_MIN_I = `TRIG_IN_MIN_CYC;
   localparam integer TOUT_MIN_I = `TRIGGER_OUTPUT_ENABLE_MIN_CYC;
   localparam [`TRIG_IN_CNT_W-1:0] TIN_MIN = TIN_MIN_I[`TRIG_IN_CNT_W-1:0];
   localparam [`TRIGGER_OUTPUT_ENABLE_CNT_W-1:0] TOUT_MIN = TOUT_MIN_I[`TRIGGER_OUTPUT_ENABLE_CNT_W-1:0];
   // last count of a valid low and the final cycle of an output pulse
   localparam [`TRIG_IN_CNT_W-1:0] TIN_LAST = TIN_MIN - {{(`TRIG_IN_CNT_W-1){1'b0}}, 1'b1};
   localparam [`TRIGGER_OUTPUT_ENABLE_CNT_W-1:0] TOUT_ZERO = {`TRIGGER_OUTPUT_ENABLE_CNT_W{1'b0}};
   localparam [`TRIGGER_OUTPUT_ENABLE_CNT_W-1:0] TOUT_ONE = {{(`TRIGGER_OUTPUT_ENABLE_CNT_W-1){1'b0}}, 1'b1};
   // trigger input states, one-hot
   localparam [2:0] TI_IDLE = 3'h1;
   localparam [2:0] TI_LOW = 3'h2;
   localparam [2:0] TI_VALID = 3'h4;

   reg [31:0] ctrl_q;
   reg [2:0] ti_state_q;
   reg [2:0] ti_state_d;
   reg [`TRIG_IN_CNT_W-1:0] ti_cnt_q;
   reg [`TRIGGER_OUTPUT_ENABLE_CNT_W-1:0] to_cnt_q;
   reg paused_q;
   reg resumed_q;
   reg [1:0] range_q;
   reg [1:0] range_d;
   reg trig_fire;
   wire [3:0] sync_out;
   wire sel1_s;
   wire sel0_s;
   wire trig_s;
   wire alarm_s;
   wire [1:0] mode;
   wire [1:0] man_range;
   wire ext_active;
   wire trig_accept;
   wire wr_ctrl;
   wire wr_event;
   // decoded events, alarm level and read data
   wire ev_dyn;
   wire ev_step;
   wire ev_clear;
   wire alarm_now;
   wire ti_long;
   reg [31:0] rdata_d;

   // range code from the two select pins
   function [1:0] decode_range;
      input s1;
      input s0;
      begin
         if (s1 && s0) begin
            decode_range = `RANGE_H;
         end else if (s1) begin
            decode_range = `RANGE_M;
         end else if (s0) begin
            decode_range = `RANGE_L;
         end else begin
            decode_range = `RANGE_H;
         end
      end
   endfunction

   // synchronise control inputs
   sync2 #(
      .W(4)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .d({range_sel1_n, range_sel0_n, trig_in_n, alarm_in_n}),
      .q(sync_out)
   );

   assign sel1_s = sync_out[3];
   assign sel0_s = sync_out[2];
   assign trig_s = sync_out[1];
   assign alarm_s = sync_out[0];

   // configuration fields
   assign mode = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
   assign man_range = ctrl_q[`CTRL_MRANGE_MSB:`CTRL_MRANGE_LSB];
   assign ext_active = (mode == `CTRL_V) || (mode == `CTRL_R) || (mode == `CTRL_RIV);
   assign wr_ctrl = wr && (addr == `REG_CTRL);
   assign wr_event = wr && (addr == `REG_EVENT);

   // event bits, each fires only with a write to the event register
   assign ev_dyn = wr_event && wdata[`EV_DYN_SWITCH];
   assign ev_step = wr_event && wdata[`EV_SEQ_STEP];
   assign ev_clear = wr_event && wdata[`EV_MSG_CLEAR];
   // alarm seen while external control is on, from instrument or slave alike
   assign alarm_now = ext_active && !alarm_s;

   // control register
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= wdata;
      end
   end

   // active range: external choice only from manual high range
   always @* begin
      range_d = man_range;
      if (ext_active && (man_range == `RANGE_H)) begin
         range_d = decode_range(sel1_s, sel0_s);
      end
   end

   // trigger input pulse measurement
   always @* begin
      ti_state_d = ti_state_q;
      case (ti_state_q)
         TI_IDLE: begin
            if (!trig_s) begin
               ti_state_d = TI_LOW;
            end
         end
         TI_LOW: begin
            if (trig_s) begin
               ti_state_d = TI_IDLE; // too short, invalid
            end else if (ti_long) begin
               ti_state_d = TI_VALID;
            end
         end
         TI_VALID: begin
            if (trig_s) begin
               ti_state_d = TI_IDLE;
            end
         end
         default: begin
            ti_state_d = TI_IDLE;
         end
      endcase
   end

   // trigger accepted on the rising edge after a long enough low
   assign trig_accept = (ti_state_q == TI_VALID) && trig_s && ext_active;

   // the count holds every low sample so far, the one seen in idle included
   assign ti_long = (ti_cnt_q >= TIN_LAST);

   // trigger input state register
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ti_state_q <= TI_IDLE;
      end else begin
         ti_state_q <= ti_state_d;
      end
   end

   // low time counter: counts from the first low sample seen in idle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ti_cnt_q <= {`TRIG_IN_CNT_W{1'b0}};
      end else if ((ti_state_q != TI_VALID) && !trig_s) begin
         ti_cnt_q <= ti_cnt_q + 1'b1;
      end else begin
         ti_cnt_q <= {`TRIG_IN_CNT_W{1'b0}};
      end
   end

   // trigger output sources
   always @* begin
      trig_fire = 1'b0;
      if (ev_dyn) begin
         trig_fire = 1'b1;
      end
      if (ev_step && ctrl_q[`CTRL_TRIGGER_OUTPUT_ENABLE_EN]) begin
         trig_fire = 1'b1;
      end
   end

   // trigger output pulse stretcher
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         to_cnt_q <= {`TRIGGER_OUTPUT_ENABLE_CNT_W{1'b0}};
         trigger_output_enable <= 1'b0;
      end else begin
         if (trig_fire) begin
            to_cnt_q <= TOUT_MIN;
            trigger_output_enable <= 1'b1;
         end else if (to_cnt_q != TOUT_ZERO) begin
            to_cnt_q <= to_cnt_q - 1'b1;
            trigger_output_enable <= (to_cnt_q != TOUT_ONE);
         end else begin
            trigger_output_enable <= 1'b0;
         end
      end
   end

   // sequence pause flag: a resume wins over a pause written in the same cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         paused_q <= 1'b0;
         resumed_q <= 1'b0;
      end else if (trig_accept && paused_q) begin
         paused_q <= 1'b0;
         resumed_q <= 1'b1;
      end else if (wr_ctrl && wdata[`CTRL_SEQ_PAUSED]) begin
         paused_q <= 1'b1;
         resumed_q <= 1'b0;
      end
   end

   // one-cycle resume pulse to the sequencer
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         seq_resume <= 1'b0;
      end else begin
         seq_resume <= trig_accept && paused_q;
      end
   end

   // active range and its two status outputs
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         range_q <= `RANGE_H;
         range_status1 <= 1'b0;
         range_status0 <= 1'b0;
      end else begin
         range_q <= range_d;
         range_status1 <= (range_d == `RANGE_L);
         range_status0 <= (range_d == `RANGE_M);
      end
   end

   // load and short relay outputs follow the control register
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         load_on_status <= 1'b0;
         short_contact <= 1'b0;
      end else begin
         load_on_status <= ctrl_q[`CTRL_LOAD_ON];
         short_contact <= ctrl_q[`CTRL_SHORT];
      end
   end

   // alarm level, held while the synchronised input stays low
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         alarm_active <= 1'b0;
      end else begin
         alarm_active <= alarm_now;
      end
   end

   // sticky alarm message: a new alarm wins over a clear in the same cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         external_alarm_message <= 1'b0;
      end else if (alarm_now) begin
         external_alarm_message <= 1'b1;
      end else if (ev_clear) begin
         external_alarm_message <= 1'b0;
      end
   end

   // status word as software sees it, built field by field
   function [31:0] status_word;
      input ext_on;
      input resumed_in;
      input paused_in;
      input msg_in;
      input alarm_in;
      input [1:0] range_in;
      begin
         status_word = 32'h00000000;
         status_word[`ST_RANGE_MSB:`ST_RANGE_LSB] = range_in;
         status_word[`ST_ALARM] = alarm_in;
         status_word[`ST_ALARM_MSG] = msg_in;
         status_word[`ST_PAUSED] = paused_in;
         status_word[`ST_RESUMED] = resumed_in;
         status_word[`ST_EXT_ACTIVE] = ext_on;
      end
   endfunction

   // read data selected while the strobe stands, zero otherwise
   always @* begin
      rdata_d = 32'h00000000;
      if (rd) begin
         case (addr)
            `REG_CTRL: begin
               rdata_d = ctrl_q;
            end
            `REG_STATUS: begin
               rdata_d = status_word(ext_active, resumed_q, paused_q, external_alarm_message,
                                     alarm_active, range_q);
            end
            default: begin
               rdata_d = 32'h00000000;
            end
         endcase
      end
   end

   // read data register, valid in the cycle after the strobe only
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= rdata_d;
      end
   end
endmodule

// [rtl/sync2.v]
// two-stage synchroniser for a group of level inputs
// assumes inputs may change at any time relative to clk
`timescale 1ns/1ps
module sync2 #(
   parameter W = 4
) (
   input wire clk, // system clock
   input wire rst, // asynchronous reset, active high
   input wire [W-1:0] d, // raw inputs
   output wire [W-1:0] q // synchronised inputs
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // first stage is read only by the second
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= {W{1'b1}};
         sync_q <= {W{1'b1}};
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule

// [sim/ext_ctrl_model.sv]
// external controller model: drives range select, trigger and alarm pins
// assumes commands from the bench; a released switch reads high
`timescale 1ns/1ps
module ext_ctrl_model (
   input wire clk, // clock
   input wire [1:0] close_sel, // closed range switches, upper then lower
   input wire alarm_on, // alarm switch closed
   input wire trig_go, // start a trigger pulse
   input wire [11:0] trig_len, // low time in cycles
   output wire range_sel1_n, // upper select pin
   output wire range_sel0_n, // lower select pin
   output wire trig_in_n, // trigger pin
   output wire alarm_in_n // alarm pin
);
   reg [11:0] cnt_q = 12'h000;
   // open switches float high through the pull-ups
   assign range_sel1_n = ~close_sel[1];
   assign range_sel0_n = ~close_sel[0];
   assign alarm_in_n = ~alarm_on;
   // hold the trigger low for the asked span, then release
   always @(posedge clk) begin
      if (trig_go) begin
         cnt_q <= trig_len;
      end else if (cnt_q != 12'h000) begin
         cnt_q <= cnt_q - 12'h001;
      end
   end
   assign trig_in_n = (cnt_q == 12'h000);
endmodule

// [sim/external_control_io_asserts.sv]
// assertions on the external control i/o ports
// assumes one clock and the active-high asynchronous reset
`timescale 1ns/1ps
module external_control_io_asserts (
   input wire clk, // clock
   input wire rst, // reset
   input wire [3:0] addr, // address
   input wire [31:0] wdata, // write data
   input wire wr, // write strobe
   input wire rd, // read strobe
   input wire [31:0] rdata, // read data
   input wire trig_in_n, // trigger pin
   input wire alarm_in_n, // alarm pin
   input wire load_on_status, // load status
   input wire range_status1, // low range status
   input wire range_status0, // middle range status
   input wire short_contact, // short relay
   input wire trigger_output_enable, // trigger pulse
   input wire alarm_active, // alarm level
   input wire external_alarm_message, // alarm message
   input wire seq_resume // resume pulse
);
   reg [7:0] hi_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // length of the current trigger output pulse, saturating
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         hi_q <= 8'h00;
      end else begin
         hi_q <= !trigger_output_enable ? 8'h00 : (hi_q == 8'hff) ? hi_q : hi_q + 8'h01;
      end
   end
   a_status_exclusive: assert property (!(range_status1 && range_status0))
      else $error("both range status outputs on");
   a_load_follows: assert property (wr && addr == 4'h0 && wdata[4] |-> ##[1:2] load_on_status)
      else $error("load status not on after write");
   a_short_opens: assert property (wr && addr == 4'h0 && !wdata[5] |-> ##[1:2] !short_contact)
      else $error("short contact not open after write");
   a_trig_fires: assert property (wr && addr == 4'h4 && wdata[0] |-> ##[1:2] trigger_output_enable)
      else $error("no trigger pulse on dynamic switch");
   a_trig_width: assert property ($fell(trigger_output_enable) |-> hi_q >= 8'hc8)
      else $error("trigger pulse too short");
   a_msg_with_alarm: assert property ($rose(alarm_active) |-> ##[0:1] external_alarm_message)
      else $error("alarm without message");
   a_alarm_cause: assert property ($past(alarm_in_n, 2) && $past(alarm_in_n, 3) && $past(alarm_in_n, 4)
      |-> !alarm_active)
      else $error("alarm active with input high");
   a_resume_pulse: assert property (seq_resume |=> !seq_resume)
      else $error("resume longer than one cycle");
   a_resume_cause: assert property (seq_resume |-> $past(trig_in_n, 3))
      else $error("resume before trigger released");
   a_read_idle: assert property (!rd |=> rdata == 32'h00000000)
      else $error("read data outside read cycle");
endmodule
bind external_control_io external_control_io_asserts u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .trig_in_n(trig_in_n), .alarm_in_n(alarm_in_n),
   .load_on_status(load_on_status), .range_status1(range_status1), .range_status0(range_status0),
   .short_contact(short_contact), .trigger_output_enable(trigger_output_enable), .alarm_active(alarm_active),
   .external_alarm_message(external_alarm_message), .seq_resume(seq_resume));

// [sim/external_control_io_tb.sv]
// testbench for the external control i/o block
// assumes the controller model on the pins and register access by strobes
`timescale 1ns/1ps
module external_control_io_tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [3:0] addr = 4'h0;
   reg [31:0] wdata = 32'h0;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg [1:0] close_sel = 2'h0;
   reg alarm_on = 1'b0;
   reg trig_go = 1'b0;
   reg [11:0] trig_len = 12'h000;
   wire [31:0] rdata;
   wire sel1_n, sel0_n, trg_n, alm_n, load_on, rs1, rs0, short_c, trigger_output_enable, alarm_act, msg, resume;
   integer n_mismatch = 0;
   integer total_checks = 0;
   integer n_res = 0;
   integer n_hi = 0;
   integer base, i;
   always #5 clk = ~clk;
   external_control_io u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .range_sel1_n(sel1_n), .range_sel0_n(sel0_n), .trig_in_n(trg_n), .alarm_in_n(alm_n),
      .load_on_status(load_on), .range_status1(rs1), .range_status0(rs0), .short_contact(short_c),
      .trigger_output_enable(trigger_output_enable), .alarm_active(alarm_act), .external_alarm_message(msg), .seq_resume(resume));
   ext_ctrl_model u_far (.clk(clk), .close_sel(close_sel), .alarm_on(alarm_on), .trig_go(trig_go),
      .trig_len(trig_len), .range_sel1_n(sel1_n), .range_sel0_n(sel0_n), .trig_in_n(trg_n), .alarm_in_n(alm_n));
   // count resume pulses and trigger output high cycles
   always @(posedge clk) begin
      n_res <= n_res + resume;
      n_hi <= n_hi + trigger_output_enable;
   end
   task check(input [31:0] seen, input [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr_reg(input [3:0] a, input [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_chk(input [3:0] a, input [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, e);
   endtask
   task settle(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task pulse(input [11:0] len);
      @(posedge clk);
      trig_go <= 1'b1;
      trig_len <= len;
      @(posedge clk);
      trig_go <= 1'b0;
      settle(len + 12);
   endtask
   task done(input string s);
      $display("test %0s done", s);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // stop a hung run
   initial begin
      #100000;
      n_mismatch = n_mismatch + 1;
      give_verdict;
   end
   // main test sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd_chk(4'h0, 32'h0);
      rd_chk(4'h8, 32'h0);
      rd_chk(4'hc, 32'h0);
      done("reset");
      @(posedge clk) begin close_sel <= 2'h2; alarm_on <= 1'b1; end
      settle(6);
      check({rs1, rs0}, 2'h0);
      check(alarm_act, 1'b0);
      done("ext off");
      wr_reg(4'h0, 32'h31);
      settle(6);
      check({alarm_act, msg}, 2'h3);
      check({load_on, short_c}, 2'h3);
      @(posedge clk) alarm_on <= 1'b0;
      settle(6);
      check({alarm_act, msg}, 2'h1);
      rd_chk(4'h8, 32'h4a);
      wr_reg(4'h4, 32'h4);
      settle(2);
      check(msg, 1'b0);
      done("alarm");
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge clk) close_sel <= i;
         settle(5);
         check({rs1, rs0}, (i == 1) ? 2'h1 : (i == 2) ? 2'h2 : 2'h0);
      end
      @(posedge clk) close_sel <= 2'h2;
      wr_reg(4'h0, 32'h35);
      settle(5);
      check({rs1, rs0}, 2'h1);
      wr_reg(4'h0, 32'h01);
      settle(5);
      check({load_on, short_c, rs1, rs0}, 4'h2);
      wr_reg(4'h0, 32'h02);
      rd_chk(4'h8, 32'h42);
      wr_reg(4'h0, 32'h03);
      rd_chk(4'h8, 32'h42);
      done("range");
      wr_reg(4'h0, 32'h81);
      rd_chk(4'h8, 32'h52);
      pulse(12'd999);
      check(n_res, 0);
      pulse(12'd1000);
      check(n_res, 1);
      rd_chk(4'h8, 32'h62);
      pulse(12'd1000);
      check(n_res, 1);
      wr_reg(4'h0, 32'h80);
      pulse(12'd1000);
      check(n_res, 1);
      done("trigger in");
      base = n_hi;
      wr_reg(4'h4, 32'h1);
      settle(210);
      check(n_hi - base, 200);
      wr_reg(4'h4, 32'h2);
      settle(210);
      check(n_hi - base, 200);
      wr_reg(4'h0, 32'h41);
      wr_reg(4'h4, 32'h2);
      settle(210);
      check(n_hi - base, 400);
      done("trigger out");
      give_verdict;
   end
endmodule
